//--- rtl/tac_conv_ctrl.sv
// Conversion control: mode, channel sequencing, acquisition window and repeat interval timer
//
// Our own choice: the address-and-strobe port.
`include "tac_map.svh"

module tac_conv_ctrl #(
	parameter int RPT_BASE_TICKS = `TAC_RPT_BASE_OSC,
	parameter int RPT_STEP_TICKS = `TAC_RPT_STEP_OSC
) (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [15:0]      reg_rdata,
	input  wire logic        pen_down,
	input  wire logic        adc_done,
	output logic             adc_sample,
	output logic             adc_start,
	output logic [2:0]       adc_channel,
	output logic             seq_busy
);
	import tac_pkg::*;

	tac_ctl_type st_ff;
	tac_ctl_type nxt_st;

	logic        tmr_load;
	logic [15:0] tmr_ticks;
	logic        tmr_halt;
	logic        tmr_expired;
	logic        tmr_running;

	tac_tick_timer u_timer (
		.clk_sys    (clk_sys),
		.reset_n    (reset_n),
		.load       (tmr_load),
		.load_ticks (tmr_ticks),
		.halt       (tmr_halt),
		.expired    (tmr_expired),
		.running    (tmr_running)
	);

	// Drops channels the pin function or the battery priority rules out
	function automatic logic [7:0] filter_mask(input logic [7:0] mask, input logic gpio_on);
		logic [7:0] m;
		m = mask;
		m[0] = 1'b0;
		if (gpio_on) begin
			m[`TAC_CH_VBAT] = 1'b0;
			m[`TAC_CH_AUX] = 1'b0;
		end else if (m[`TAC_CH_VBAT] && m[`TAC_CH_AUX]) begin
			m[`TAC_CH_AUX] = 1'b0;
		end
		return m;
	endfunction

	// Highest enabled channel code strictly below the given bound, 0 when none is left
	function automatic logic [2:0] next_chan(input logic [7:0] mask, input logic [3:0] below);
		logic [2:0] pick;
		pick = `TAC_CH_NONE;
		for (int i = 1; i < 8; i++) begin
			if (mask[i] && (4'(i) < below)) begin
				pick = 3'(i);
			end
		end
		return pick;
	endfunction

	logic [1:0]  mode;
	logic [2:0]  chan_sel;
	logic [1:0]  win_len;
	logic [7:0]  rpt_code;
	logic        gpio_on;
	logic [7:0]  run_mask;
	logic [2:0]  pick;
	logic [15:0] rpt_ticks;
	logic        ctrl1_wr;
	logic        start_req;

	always_comb begin
		mode = st_ff.ctrl1[`TAC_MODE_MSB:`TAC_MODE_LSB];
		chan_sel = st_ff.ctrl1[`TAC_CH_MSB:`TAC_CH_LSB];
		win_len = st_ff.ctrl1[`TAC_WIN_MSB:`TAC_WIN_LSB];
		rpt_code = st_ff.ctrl1[`TAC_RPT_MSB:`TAC_RPT_LSB];
		gpio_on = st_ff.ctrl2[`TAC_GPIO_EN_BIT];
		if (mode == `TAC_MODE_SINGLE) begin
			run_mask = filter_mask(8'h01 << chan_sel, gpio_on);
		end else begin
			run_mask = filter_mask(st_ff.ctrl3[`TAC_SEQ_MSB:`TAC_SEQ_LSB], gpio_on);
		end
		pick = next_chan(run_mask, st_ff.below);
		// Code 0 never reaches the timer, so the wrap of code minus one is harmless
		rpt_ticks = 16'(RPT_BASE_TICKS + (int'(rpt_code) - 1) * RPT_STEP_TICKS);
		ctrl1_wr = reg_wr && (reg_addr == `TAC_OFF_CTRL1);
		start_req = ctrl1_wr && (reg_wdata[`TAC_MODE_MSB:`TAC_MODE_LSB] != `TAC_MODE_OFF);
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.rdata = 16'h0000;
		nxt_st.adc_start = 1'b0;
		tmr_load = 1'b0;
		tmr_ticks = 16'h0000;
		tmr_halt = 1'b0;

		case (st_ff.state)
			st_idle: begin
				nxt_st.adc_sample = 1'b0;
				if (start_req) begin
					nxt_st.below = 4'h8;
					if (reg_wdata[`TAC_MODE_MSB:`TAC_MODE_LSB] == `TAC_MODE_MASTER) begin
						nxt_st.state = st_pen_wait;
					end else begin
						nxt_st.state = st_select;
					end
				end
			end
			st_pen_wait: begin
				nxt_st.below = 4'h8;
				if (pen_down) begin
					nxt_st.state = st_select;
				end
			end
			st_select: begin
				if (pick == `TAC_CH_NONE) begin
					nxt_st.state = st_finish;
				end else begin
					nxt_st.cur_chan = pick;
					nxt_st.adc_channel = pick;
					nxt_st.adc_sample = 1'b1;
					tmr_load = 1'b1;
					if (pick == `TAC_CH_TEMP) begin
						tmr_ticks = 16'(`TAC_TEMP_SETTLE_OSC);
					end else begin
						tmr_ticks = 16'(`TAC_WIN_BASE_OSC) << win_len;
					end
					nxt_st.state = st_acquire;
				end
			end
			st_acquire: begin
				if (tmr_expired) begin
					nxt_st.adc_sample = 1'b0;
					nxt_st.adc_start = 1'b1;
					nxt_st.state = st_convert;
				end
			end
			st_convert: begin
				// Waits on the converter; a stuck converter is cleared by writing mode 00
				if (adc_done) begin
					nxt_st.below = {1'b0, st_ff.cur_chan};
					nxt_st.state = st_select;
				end
			end
			st_finish: begin
				nxt_st.below = 4'h8;
				if (mode == `TAC_MODE_MASTER) begin
					if (!pen_down) begin
						nxt_st.state = st_pen_wait;
					end else if (rpt_code == 8'h00) begin
						nxt_st.state = st_select;
					end else begin
						tmr_load = 1'b1;
						tmr_ticks = rpt_ticks;
						nxt_st.state = st_interval;
					end
				end else if (rpt_code == 8'h00) begin
					nxt_st.ctrl1[`TAC_MODE_MSB:`TAC_MODE_LSB] = `TAC_MODE_OFF;
					nxt_st.state = st_idle;
				end else begin
					tmr_load = 1'b1;
					tmr_ticks = rpt_ticks;
					nxt_st.state = st_interval;
				end
			end
			st_interval: begin
				nxt_st.below = 4'h8;
				if ((mode == `TAC_MODE_MASTER) && !pen_down) begin
					tmr_halt = 1'b1;
					nxt_st.state = st_pen_wait;
				end else if (tmr_expired) begin
					nxt_st.state = st_select;
				end
			end
			default: begin
				nxt_st.state = st_idle;
			end
		endcase

		// Mode 00 aborts any activity in progress
		if ((st_ff.state != st_idle) && (mode == `TAC_MODE_OFF)) begin
			tmr_halt = 1'b1;
			nxt_st.adc_sample = 1'b0;
			nxt_st.adc_start = 1'b0;
			nxt_st.state = st_idle;
		end

		// A host write lands after the sequencer so the newer setting wins
		if (reg_wr) begin
			case (reg_addr)
				`TAC_OFF_CTRL1: nxt_st.ctrl1 = reg_wdata;
				`TAC_OFF_CTRL2: nxt_st.ctrl2 = reg_wdata;
				`TAC_OFF_CTRL3: nxt_st.ctrl3 = reg_wdata;
				default: begin
				end
			endcase
		end

		if (reg_rd) begin
			case (reg_addr)
				`TAC_OFF_CTRL1: nxt_st.rdata = st_ff.ctrl1;
				`TAC_OFF_CTRL2: nxt_st.rdata = st_ff.ctrl2;
				`TAC_OFF_CTRL3: nxt_st.rdata = st_ff.ctrl3;
				`TAC_OFF_STATUS: begin
					nxt_st.rdata = {8'h00,
						(st_ff.state == st_pen_wait),
						tmr_running,
						st_ff.adc_sample,
						st_ff.seq_busy,
						1'b0,
						st_ff.cur_chan};
				end
				default: nxt_st.rdata = 16'h0000;
			endcase
		end

		nxt_st.seq_busy = (nxt_st.state != st_idle) && (nxt_st.state != st_pen_wait);
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st_ff <= '{ctrl1: `TAC_CTRL1_RST,
				ctrl2: `TAC_CTRL2_RST,
				ctrl3: `TAC_CTRL3_RST,
				state: st_idle,
				cur_chan: 3'h0,
				below: 4'h8,
				rdata: 16'h0000,
				adc_sample: 1'b0,
				adc_start: 1'b0,
				adc_channel: 3'h0,
				seq_busy: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata = st_ff.rdata;
	assign adc_sample = st_ff.adc_sample;
	assign adc_start = st_ff.adc_start;
	assign adc_channel = st_ff.adc_channel;
	assign seq_busy = st_ff.seq_busy;

endmodule

//--- rtl/tac_map.svh
// Register map, field positions, reset values and timing counts of the conversion control
`ifndef TAC_MAP_SVH
`define TAC_MAP_SVH

`define TAC_OFF_CTRL1        8'h01
`define TAC_OFF_CTRL2        8'h02
`define TAC_OFF_CTRL3        8'h03
`define TAC_OFF_STATUS       8'h0F

`define TAC_CTRL1_RST        16'h0000
`define TAC_CTRL2_RST        16'h4040
`define TAC_CTRL3_RST        16'h0000

`define TAC_CH_MSB           14
`define TAC_CH_LSB           12
`define TAC_MODE_MSB         11
`define TAC_MODE_LSB         10
`define TAC_WIN_MSB          9
`define TAC_WIN_LSB          8
`define TAC_RPT_MSB          7
`define TAC_RPT_LSB          0
`define TAC_GPIO_EN_BIT      13
`define TAC_SEQ_MSB          7
`define TAC_SEQ_LSB          0

`define TAC_CH_NONE          3'h0
`define TAC_CH_TEMP          3'h1
`define TAC_CH_VBAT          3'h2
`define TAC_CH_AUX           3'h3

`define TAC_MODE_OFF         2'h0
`define TAC_MODE_SINGLE      2'h1
`define TAC_MODE_SLAVE       2'h2
`define TAC_MODE_MASTER      2'h3

`define TAC_CLK_NS           50
`define TAC_OSC_NS           500
`define TAC_OSC_DIV          (`TAC_OSC_NS / `TAC_CLK_NS)
`define TAC_WIN_BASE_OSC     4
`define TAC_TEMP_SETTLE_US   16
`define TAC_TEMP_SETTLE_OSC  ((`TAC_TEMP_SETTLE_US * 1000) / `TAC_OSC_NS)
`define TAC_RPT_BASE_US      550
`define TAC_RPT_STEP_US      35
`define TAC_RPT_BASE_OSC     ((`TAC_RPT_BASE_US * 1000) / `TAC_OSC_NS)
`define TAC_RPT_STEP_OSC     ((`TAC_RPT_STEP_US * 1000) / `TAC_OSC_NS)

`endif

//--- rtl/tac_pkg.sv
// Types shared by the conversion control modules
package tac_pkg;

	typedef enum logic [2:0] {
		st_idle,
		st_pen_wait,
		st_select,
		st_acquire,
		st_convert,
		st_finish,
		st_interval
	} tac_state_type;

	typedef struct packed {
		logic [3:0]  div;
		logic [15:0] cnt;
		logic        run;
		logic        expired;
	} tac_tmr_type;

	typedef struct packed {
		logic [15:0]   ctrl1;
		logic [15:0]   ctrl2;
		logic [15:0]   ctrl3;
		tac_state_type state;
		logic [2:0]    cur_chan;
		logic [3:0]    below;
		logic [15:0]   rdata;
		logic          adc_sample;
		logic          adc_start;
		logic [2:0]    adc_channel;
		logic          seq_busy;
	} tac_ctl_type;

endpackage

//--- rtl/tac_tick_timer.sv
// Oscillator-tick down counter used for acquisition windows and repeat intervals
`include "tac_map.svh"

module tac_tick_timer (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        load,
	input  wire logic [15:0] load_ticks,
	input  wire logic        halt,
	output logic             expired,
	output logic             running
);
	import tac_pkg::*;

	localparam logic [3:0] DIV_LAST = 4'(`TAC_OSC_DIV - 1);

	tac_tmr_type tmr_ff;
	tac_tmr_type nxt_tmr;

	always_comb begin
		nxt_tmr = tmr_ff;
		nxt_tmr.expired = 1'b0;
		if (halt) begin
			nxt_tmr.run = 1'b0;
			nxt_tmr.div = 4'h0;
		end else if (load) begin
			// Load cycle counts as the first divider step, so a window is exactly N periods
			nxt_tmr.cnt = load_ticks;
			nxt_tmr.div = 4'h1;
			nxt_tmr.run = (load_ticks != 16'h0000);
			nxt_tmr.expired = (load_ticks == 16'h0000);
		end else if (tmr_ff.run) begin
			if (tmr_ff.div == DIV_LAST) begin
				nxt_tmr.div = 4'h0;
				nxt_tmr.cnt = tmr_ff.cnt - 16'h0001;
				if (tmr_ff.cnt == 16'h0001) begin
					nxt_tmr.run = 1'b0;
					nxt_tmr.expired = 1'b1;
				end
			end else begin
				nxt_tmr.div = tmr_ff.div + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			tmr_ff <= '0;
		end else begin
			tmr_ff <= nxt_tmr;
		end
	end

	assign expired = tmr_ff.expired;
	assign running = tmr_ff.run;

endmodule

//--- tb/tac_adc_model.sv
// Behavioural converter answering each start after a chosen delay
module tac_adc_model (
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	input  wire logic       adc_start,
	input  wire logic [4:0] lat,
	output logic            adc_done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] cnt_ff;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cnt_ff   <= 6'h00;
			adc_done <= 1'b0;
		end else begin
			adc_done <= (cnt_ff == 6'h01);
			if (adc_start)
				cnt_ff <= {1'b0, lat} + 6'h01;
			else if (cnt_ff != 6'h00)
				cnt_ff <= cnt_ff - 6'h01;
		end
	end
endmodule

//--- tb/tac_conv_ctrl_props.sv
// Port assertions of the conversion control
module tac_conv_ctrl_props #(
	parameter int RPT_BASE_TICKS = 1100,
	parameter int RPT_STEP_TICKS = 70
) (
	input wire logic        clk_sys,
	input wire logic        reset_n,
	input wire logic [7:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        pen_down,
	input wire logic        adc_done,
	input wire logic        adc_sample,
	input wire logic        adc_start,
	input wire logic [2:0]  adc_channel,
	input wire logic        seq_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [9:0] len_ff;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			len_ff <= 10'h000;
		else
			len_ff <= adc_sample ? len_ff + 10'h001 : 10'h000;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	a_window_len: assert property (adc_start && adc_channel != 3'h1
		|-> len_ff inside {10'h028, 10'h050, 10'h0A0, 10'h140}) else $error("bad acquisition length");
	a_temp_settle: assert property (adc_start && adc_channel == 3'h1 |-> len_ff == 10'h140)
		else $error("bad temperature settling");
	a_chan_valid: assert property (adc_sample |-> adc_channel != 3'h0)
		else $error("sampling with no channel");
	a_start_pulse: assert property (adc_start |-> $fell(adc_sample) ##1 !adc_start)
		else $error("start not a pulse at window end");
	a_chan_stable: assert property (adc_sample && !$rose(adc_sample) |-> $stable(adc_channel))
		else $error("channel moved in window");
	a_single_start: assert property (reg_wr && reg_addr == 8'h01 && reg_wdata[14:10] == 5'h1D
		&& !seq_busy |-> ##2 adc_sample && adc_channel == 3'h7) else $error("single start late");
	a_abort_idle: assert property (reg_wr && reg_addr == 8'h01 && reg_wdata[11:10] == 2'h0
		|-> ##3 !seq_busy && !adc_sample) else $error("abort not idle");
	a_sample_busy: assert property (adc_sample |-> seq_busy)
		else $error("sampling while idle");
	cover property (adc_start && adc_channel == 3'h1);
	cover property ($fell(seq_busy));
	cover property (pen_down && $rose(adc_sample));
endmodule

bind tac_conv_ctrl tac_conv_ctrl_props #(
	.RPT_BASE_TICKS(RPT_BASE_TICKS),
	.RPT_STEP_TICKS(RPT_STEP_TICKS)
) tac_conv_ctrl_props_i (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pen_down(pen_down), .adc_done(adc_done),
	.adc_sample(adc_sample), .adc_start(adc_start), .adc_channel(adc_channel), .seq_busy(seq_busy));

//--- tb/tac_conv_ctrl_tb_top.sv
// Self-checking bench for the conversion control
module tac_conv_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys, reset_n, reg_wr, reg_rd, pen_down, adc_done, adc_sample, adc_start, seq_busy;
	logic        rd_pend;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, d;
	logic [2:0]  adc_channel;
	logic [4:0]  lat;
	logic [9:0]  len;
	int          num_errors, cmp_count;
	logic [12:0] cq[$];
	logic [15:0] rq[$];

	tac_conv_ctrl #(.RPT_BASE_TICKS(5), .RPT_STEP_TICKS(2)) tac_conv_ctrl_i (.clk_sys(clk_sys),
		.reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pen_down(pen_down), .adc_done(adc_done), .adc_sample(adc_sample),
		.adc_start(adc_start), .adc_channel(adc_channel), .seq_busy(seq_busy));
	tac_adc_model tac_adc_model_i (.clk_sys(clk_sys), .reset_n(reset_n), .adc_start(adc_start), .lat(lat),
		.adc_done(adc_done));

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic fail(input string m);
		num_errors++;
		$display("[FAIL] %0t %s", $time, m);
	endtask
	task automatic summarize();
		$display("errors %0d comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk_conv(input logic [12:0] got);
		cmp_count++;
		if (got !== cq.pop_front()) fail("conversion channel or window");
	endtask
	task automatic chk_rd(input logic [15:0] got);
		cmp_count++;
		if (got !== rq.pop_front()) fail("read data");
	endtask

	// Watcher: oldest expected read against each read answer, oldest note against each conversion start
	always @(posedge clk_sys) begin
		if (rd_pend === 1'b1) chk_rd(reg_rdata);
		if (adc_start === 1'b1) begin
			if (cq.size() == 0) fail("unexpected conversion");
			else chk_conv({adc_channel, len});
		end
		rd_pend = reg_rd;
		len = (adc_sample === 1'b1) ? len + 10'h001 : 10'h000;
	end

	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		rq.push_back(e);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
	endtask
	task automatic note(input logic [2:0] ch, input logic [9:0] n);
		cq.push_back({ch, n});
	endtask
	// Bounded wait for notes to drain and optionally for idle
	task automatic wait_q(input bit idle);
		int i;
		// Let the start write reach seq_busy before idle is judged
		repeat (2) @(posedge clk_sys);
		for (i = 0; i < 3000 && (cq.size() != 0 || (idle && seq_busy !== 1'b0)); i++)
			@(posedge clk_sys);
		if (i == 3000) begin
			fail("timeout");
			summarize();
		end
	endtask

	initial begin
		{reset_n, reg_wr, reg_rd, pen_down, rd_pend} = 5'h00;
		{reg_addr, reg_wdata, len, num_errors, cmp_count} = '0;
		lat = 5'h03;
		void'($urandom(32'h7A1F));
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		rd(8'h01, 16'h0000);
		rd(8'h02, 16'h4040);
		rd(8'h03, 16'h0000);
		rd(8'h0E, 16'h0000);
		wr(8'h03, 16'h000E);
		for (int w = 0; w < 5; w++) begin
			d = {1'($urandom), (w == 4) ? 3'h1 : 3'h7, 2'h1, 2'(w), 8'h00};
			lat <= 5'($urandom % 20);
			wr(8'h01, d);
			note(d[14:12], (w == 4) ? 10'h140 : (10'h028 << w));
			wait_q(1);
			rd(8'h01, d & 16'hF3FF);
		end
		wr(8'h01, 16'h0400);
		wait_q(1);
		rd(8'h01, 16'h0000);
		// Aux, battery and temperature enabled: battery and temperature expected, aux dropped
		wr(8'h01, 16'h0801);
		repeat (2) begin
			note(3'h2, 10'h028);
			note(3'h1, 10'h140);
		end
		wait_q(0);
		wr(8'h01, 16'h0000);
		wait_q(1);
		wr(8'h02, 16'h6040);
		wr(8'h01, 16'h0800);
		note(3'h1, 10'h140);
		wait_q(1);
		rd(8'h01, 16'h0000);
		wr(8'h02, 16'h4040);
		wr(8'h01, 16'h0C01);
		repeat (100) @(posedge clk_sys);
		pen_down <= 1'b1;
		note(3'h2, 10'h028);
		note(3'h1, 10'h140);
		wait_q(0);
		pen_down <= 1'b0;
		repeat (100) @(posedge clk_sys);
		pen_down <= 1'b1;
		note(3'h2, 10'h028);
		note(3'h1, 10'h140);
		wait_q(0);
		wr(8'h01, 16'h0000);
		pen_down <= 1'b0;
		wait_q(1);
		summarize();
	end
endmodule
